/* File: core/tt_thermostat.sv */
// Thermometer/thermostat core with three-wire serial port.
//
// Overview of operation
// - Temperature is nine-bit two's complement, half a degree per count.
// - Upper trip output high while temperature is at or above upper limit.
// - Lower trip output high while temperature is at or below lower limit.
// - Combined output sets at upper limit, clears at lower limit.
// - Config byte: done, over, under, busy, 1, 0, host-use, single.
// - Done reads 0 during a conversion, 1 otherwise and after reset.
// - Sticky over flag sets at upper limit, cleared only by writing 0.
// - Sticky under flag sets at lower limit, cleared only by writing 0.
// - Busy bit is 1 during a nonvolatile write of up to 10 ms.
// - Host-use 0 with select low makes the clock pin a convert pin.
// - Single mode converts once per start; otherwise converts continuously.
// - In single mode trip outputs hold the last valid conversion.
// - Serial port always works; host-use 1 disables pin conversions.
// - With host-use 0 the convert pin overrides single mode.
// - Select high starts a transfer; select low aborts and floats data.
// - Bits: falling edge then rising; input sampled rising, output on fall.
// - During reads the data pin floats while the serial clock is high.
// - Commands and data travel least significant bit first.
// - Command AAh shifts out the latest temperature over nine clocks.
// - Commands 01h and 02h take nine bits into upper and lower limit.
// - Residual count kept at conversion end; slope load on request.
// - Nine-bit or sixteen-bit transfers accepted; zeros after ninth bit.
// - EEh starts conversion; 22h stops continuous mode after current one.
`timescale 1ns/100ps

module tt_thermostat #(
    parameter int unsigned CONV_CYCLES     = tt_pkg::CONV_CYCLES_DEF,
    parameter int unsigned NV_WRITE_CYCLES = tt_pkg::NV_WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic       MCLK,
    input  wire logic       RST_N,
    // Three-wire serial port
    input  wire logic       SERIAL_SELECT,
    input  wire logic       SERIAL_CLOCK_OR_CONVERT_PIN,
    input  wire logic       DQ_IN,
    output logic            DQ_OUT,
    output logic            DQ_OE,
    // Abstract sensor front end
    input  wire logic [8:0] SENSOR_TEMP,
    input  wire logic [8:0] SENSOR_COUNT_REMAIN,
    input  wire logic [8:0] SENSOR_SLOPE,
    // Thermostat outputs
    output logic            TRIP_HIGH,
    output logic            TRIP_LOW,
    output logic            TRIP_COMBINED
);

    typedef enum logic {CV_IDLE, CV_RUN} tt_conv_t;

    // ============================================================
    // Serial port
    // ============================================================
    tt_link_if link ();

    tt_serial_port u_port (
        .clk     (MCLK),
        .rst_n   (RST_N),
        .sel_pin (SERIAL_SELECT),
        .clk_pin (SERIAL_CLOCK_OR_CONVERT_PIN),
        .dq_in   (DQ_IN),
        .dq_out  (DQ_OUT),
        .dq_oe   (DQ_OE),
        .link    (link)
    );

    // ============================================================
    // State
    // ============================================================
    logic [8:0]  temp_q;
    logic [8:0]  upper_limit_q;
    logic [8:0]  lower_limit_q;
    logic [8:0]  counter_q;
    logic        done_q;
    logic        over_q;
    logic        under_q;
    logic        nv_busy_q;
    logic        host_use_q;
    logic        single_q;
    logic        run_q;
    logic        pin_prev_q;
    logic [31:0] conv_cnt_q;
    logic [31:0] nv_cnt_q;
    tt_conv_t    conv_q;
    logic        trip_high_q;
    logic        trip_low_q;
    logic        trip_com_q;

    // ============================================================
    // Command decode
    // ============================================================
    wire cmd_start  = link.cmd_valid
                    & (link.cmd == tt_pkg::CMD_START_CONV);
    wire cmd_stop   = link.cmd_valid
                    & (link.cmd == tt_pkg::CMD_STOP_CONV);
    wire cmd_slope  = link.cmd_valid
                    & (link.cmd == tt_pkg::CMD_READ_SLOPE);
    // Limit and configuration writes are refused while the
    // nonvolatile store is still busy with the previous write.
    wire wr_ok      = link.wr_valid & ~nv_busy_q;
    wire wr_upper   = wr_ok & (link.cmd == tt_pkg::CMD_WRITE_UPPER);
    wire wr_lower   = wr_ok & (link.cmd == tt_pkg::CMD_WRITE_LOWER);
    wire wr_config  = wr_ok & (link.cmd == tt_pkg::CMD_WRITE_CONFIG);

    // ============================================================
    // Configuration/status byte and read data
    // ============================================================
    wire [7:0] config_byte;
    assign config_byte[tt_pkg::CFG_DONE]     = done_q;
    assign config_byte[tt_pkg::CFG_OVER]     = over_q;
    assign config_byte[tt_pkg::CFG_UNDER]    = under_q;
    assign config_byte[tt_pkg::CFG_NV_BUSY]  = nv_busy_q;
    assign config_byte[tt_pkg::CFG_ONE]      = 1'b1;
    assign config_byte[tt_pkg::CFG_ZERO]     = 1'b0;
    assign config_byte[tt_pkg::CFG_HOST_USE] = host_use_q;
    assign config_byte[tt_pkg::CFG_SINGLE]   = single_q;

    wire sel_temp  = (link.cmd == tt_pkg::CMD_READ_TEMP);
    wire sel_upper = (link.cmd == tt_pkg::CMD_READ_UPPER);
    wire sel_lower = (link.cmd == tt_pkg::CMD_READ_LOWER);
    wire sel_count = (link.cmd == tt_pkg::CMD_READ_COUNTER)
                   | (link.cmd == tt_pkg::CMD_READ_SLOPE);
    wire sel_cfg   = (link.cmd == tt_pkg::CMD_READ_CONFIG);

    assign link.rd_data = sel_temp  ? temp_q
                        : sel_upper ? upper_limit_q
                        : sel_lower ? lower_limit_q
                        : sel_count ? counter_q
                        : sel_cfg   ? {1'b0, config_byte}
                        : 9'h000;

    // ============================================================
    // Conversion sequencing
    // ============================================================
    // The convert pin only counts with host-use clear; the serial port
    // itself never depends on that bit.
    wire pin_active = ~host_use_q & link.pin_low;
    wire pin_fall   = pin_active & ~pin_prev_q;
    wire conv_idle  = (conv_q == CV_IDLE);
    wire conv_end   = (conv_q == CV_RUN)
                    & (conv_cnt_q == CONV_CYCLES - 32'd1);
    // A restart always passes through one idle cycle, so done shows 1
    // for at least one cycle between back-to-back conversions.
    wire conv_go    = conv_idle
                    & (cmd_start | run_q | pin_fall | pin_active);

    // Conversion results against the limits, in two's complement.
    // The sensor word is taken as a settled system-clock level; a
    // front end that changes it mid-cycle must register it first.
    wire at_upper = $signed(SENSOR_TEMP) >= $signed(upper_limit_q);
    wire at_lower = $signed(SENSOR_TEMP) <= $signed(lower_limit_q);

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            conv_q     <= CV_IDLE;
            conv_cnt_q <= 32'h0;
        end else if (conv_go) begin
            conv_q     <= CV_RUN;
            conv_cnt_q <= 32'h0;
        end else if (conv_end) begin
            conv_q     <= CV_IDLE;
        end else if (conv_q == CV_RUN) begin
            conv_cnt_q <= conv_cnt_q + 32'h1;
        end
    end

    // Continuous run flag: start sets it unless single mode is chosen,
    // stop clears it and lets the running conversion finish.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            run_q      <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_active;
            if (cmd_stop)
                run_q <= 1'b0;
            else if (cmd_start)
                run_q <= ~single_q;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N)
            done_q <= 1'b1;
        else if (conv_end)
            done_q <= 1'b1;
        else if (conv_go)
            done_q <= 1'b0;
    end

    // ============================================================
    // Conversion results
    // ============================================================
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            temp_q    <= tt_pkg::TEMP_RESET;
            counter_q <= 9'h000;
        end else begin
            if (conv_end)
                temp_q <= SENSOR_TEMP;
            if (cmd_slope)
                counter_q <= SENSOR_SLOPE;
            else if (conv_end)
                counter_q <= SENSOR_COUNT_REMAIN;
        end
    end

    // ============================================================
    // Thermostat outputs
    // ============================================================
    // Outputs only move at a conversion end, so between conversions
    // (single mode or stopped) they hold the last valid result.
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            trip_high_q <= 1'b0;
            trip_low_q  <= 1'b0;
            trip_com_q  <= 1'b0;
        end else if (conv_end) begin
            trip_high_q <= at_upper;
            trip_low_q  <= at_lower;
            if (at_upper)
                trip_com_q <= 1'b1;
            else if (at_lower)
                trip_com_q <= 1'b0;
        end
    end

    assign TRIP_HIGH     = trip_high_q;
    assign TRIP_LOW      = trip_low_q;
    assign TRIP_COMBINED = trip_com_q;

    // ============================================================
    // Sticky flags
    // ============================================================
    // A limit crossing in the same cycle as a clearing write wins.
    wire over_keep  = wr_config ? link.wr_data[tt_pkg::CFG_OVER]  : over_q;
    wire under_keep = wr_config ? link.wr_data[tt_pkg::CFG_UNDER] : under_q;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            over_q  <= 1'b0;
            under_q <= 1'b0;
        end else begin
            over_q  <= (over_q & over_keep)
                     | (conv_end & at_upper);
            under_q <= (under_q & under_keep)
                     | (conv_end & at_lower);
        end
    end

    // ============================================================
    // Limits, mode bits and nonvolatile write timing
    // ============================================================
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            upper_limit_q <= tt_pkg::UPPER_RESET;
            lower_limit_q <= tt_pkg::LOWER_RESET;
            host_use_q    <= 1'b0;
            single_q      <= 1'b0;
        end else begin
            if (wr_upper)
                upper_limit_q <= link.wr_data;
            if (wr_lower)
                lower_limit_q <= link.wr_data;
            if (wr_config) begin
                host_use_q <= link.wr_data[tt_pkg::CFG_HOST_USE];
                single_q   <= link.wr_data[tt_pkg::CFG_SINGLE];
            end
        end
    end

    // Any accepted write starts the busy time, even one that only
    // clears flags, so the host sees one rule for every write.
    wire nv_start = wr_upper | wr_lower | wr_config;
    wire nv_last  = (nv_cnt_q == NV_WRITE_CYCLES - 32'd1);

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            nv_busy_q <= 1'b0;
            nv_cnt_q  <= 32'h0;
        end else if (nv_start) begin
            nv_busy_q <= 1'b1;
            nv_cnt_q  <= 32'h0;
        end else if (nv_busy_q) begin
            nv_cnt_q <= nv_cnt_q + 32'h1;
            if (nv_last)
                nv_busy_q <= 1'b0;
        end
    end

    // Limitation: the pin override means a convert pin held low keeps
    // the sequencer busy even in single mode, so a host that wants
    // exactly one conversion must keep the pin high or set host-use.
    // Writes that arrive during the busy time are dropped rather than
    // queued, which keeps the store free of a second pending word; a
    // host must poll the busy bit before each write.

endmodule

/* File: core/tt_pkg.sv */
// Shared constants for the thermometer/thermostat core.
package tt_pkg;

    // ============================================================
    // Serial command codes
    // ============================================================
    localparam logic [7:0] CMD_READ_TEMP    = 8'haa;
    localparam logic [7:0] CMD_READ_COUNTER = 8'ha0;
    localparam logic [7:0] CMD_READ_SLOPE   = 8'ha9;
    localparam logic [7:0] CMD_START_CONV   = 8'hee;
    localparam logic [7:0] CMD_STOP_CONV    = 8'h22;
    localparam logic [7:0] CMD_WRITE_UPPER  = 8'h01;
    localparam logic [7:0] CMD_WRITE_LOWER  = 8'h02;
    localparam logic [7:0] CMD_READ_UPPER   = 8'ha1;
    localparam logic [7:0] CMD_READ_LOWER   = 8'ha2;
    localparam logic [7:0] CMD_WRITE_CONFIG = 8'h0c;
    localparam logic [7:0] CMD_READ_CONFIG  = 8'hac;

    // ============================================================
    // Word sizes and bit counts
    // ============================================================
    localparam int         TEMP_W        = 9;
    localparam int         CFG_W         = 8;
    localparam logic [3:0] CMD_LAST_BIT  = 4'h7;
    localparam logic [3:0] TEMP_LAST_BIT = 4'h8;
    localparam logic [3:0] CFG_LAST_BIT  = 4'h7;

    // ============================================================
    // Configuration/status field positions
    // ============================================================
    localparam int CFG_DONE     = 7;
    localparam int CFG_OVER     = 6;
    localparam int CFG_UNDER    = 5;
    localparam int CFG_NV_BUSY  = 4;
    localparam int CFG_ONE      = 3;
    localparam int CFG_ZERO     = 2;
    localparam int CFG_HOST_USE = 1;
    localparam int CFG_SINGLE   = 0;

    // ============================================================
    // Reset values
    // ============================================================
    localparam logic [8:0] TEMP_RESET  = 9'h188;
    localparam logic [8:0] UPPER_RESET = 9'h01e;
    localparam logic [8:0] LOWER_RESET = 9'h014;

    // ============================================================
    // Timing
    // ============================================================
    localparam int unsigned CLK_KHZ         = 50000;
    localparam int unsigned NV_WRITE_MS     = 10;
    localparam int unsigned NV_WRITE_CYCLES = NV_WRITE_MS * CLK_KHZ;
    localparam int unsigned CONV_CYCLES_DEF = 1000;

endpackage

/* File: core/tt_link_if.sv */
// Carrier between the serial port engine and the thermostat core.
`timescale 1ns/100ps

interface tt_link_if;
    logic       cmd_valid;
    logic [7:0] cmd;
    logic       wr_valid;
    logic [8:0] wr_data;
    logic [8:0] rd_data;
    logic       pin_low;

    modport port (
        output cmd_valid,
        output cmd,
        output wr_valid,
        output wr_data,
        output pin_low,
        input  rd_data
    );

    modport core (
        input  cmd_valid,
        input  cmd,
        input  wr_valid,
        input  wr_data,
        input  pin_low,
        output rd_data
    );
endinterface

/* File: core/tt_serial_port.sv */
// Three-wire serial port engine: pin sampling, command and data shifting.
`timescale 1ns/100ps

module tt_serial_port (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pins
    input  wire logic sel_pin,
    input  wire logic clk_pin,
    input  wire logic dq_in,
    output logic      dq_out,
    output logic      dq_oe,
    // Core side
    tt_link_if.port   link
);

    typedef enum logic [1:0] {PH_CMD, PH_WRITE, PH_READ, PH_DONE} tt_phase_t;

    // ============================================================
    // Pin sampling
    // ============================================================
    // Bit order is {select, clock, data}; a level is accepted once the
    // second and third stages agree, which rejects single-cycle glitches.
    logic [2:0] s1_q, s2_q, s3_q, filt_q;
    wire  [2:0] filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
    logic       clk_prev_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q       <= 3'h2;
            s2_q       <= 3'h2;
            s3_q       <= 3'h2;
            filt_q     <= 3'h2;
            clk_prev_q <= 1'b1;
        end else begin
            s1_q       <= {sel_pin, clk_pin, dq_in};
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            filt_q     <= filt_d;
            clk_prev_q <= filt_q[1];
        end
    end

    wire sel  = filt_q[2];
    wire sclk = filt_q[1];
    wire sdat = filt_q[0];
    wire rise = sclk & ~clk_prev_q;
    wire fall = ~sclk & clk_prev_q;

    // ============================================================
    // Shifting
    // ============================================================
    tt_phase_t  phase_q;
    logic [3:0] bit_q;
    logic [7:0] cmd_q;
    logic [8:0] wr_sr_q;
    logic [8:0] rd_sr_q;
    logic       loaded_q;

    wire [7:0] cmd_full = {sdat, cmd_q[7:1]};
    wire [8:0] wr_full  = {sdat, wr_sr_q[8:1]};
    wire       is_cfg   = (cmd_q == tt_pkg::CMD_WRITE_CONFIG);
    wire [3:0] wr_last  = is_cfg ? tt_pkg::CFG_LAST_BIT
                                 : tt_pkg::TEMP_LAST_BIT;
    wire       is_write = (cmd_full == tt_pkg::CMD_WRITE_UPPER)
                        | (cmd_full == tt_pkg::CMD_WRITE_LOWER)
                        | (cmd_full == tt_pkg::CMD_WRITE_CONFIG);
    wire       is_read  = (cmd_full == tt_pkg::CMD_READ_TEMP)
                        | (cmd_full == tt_pkg::CMD_READ_COUNTER)
                        | (cmd_full == tt_pkg::CMD_READ_SLOPE)
                        | (cmd_full == tt_pkg::CMD_READ_UPPER)
                        | (cmd_full == tt_pkg::CMD_READ_LOWER)
                        | (cmd_full == tt_pkg::CMD_READ_CONFIG);
    wire [8:0] rd_src   = loaded_q ? rd_sr_q : link.rd_data;

    assign link.cmd = cmd_q;

    always_ff @(posedge clk) begin
        link.pin_low <= rst_n & ~sel & ~sclk;
        link.cmd_valid <= 1'b0;
        link.wr_valid  <= 1'b0;
        if (!rst_n || !sel) begin
            phase_q  <= PH_CMD;
            bit_q    <= 4'h0;
            loaded_q <= 1'b0;
            dq_oe    <= 1'b0;
            dq_out   <= 1'b0;
            if (!rst_n) begin
                cmd_q        <= 8'h00;
                wr_sr_q      <= 9'h000;
                rd_sr_q      <= 9'h000;
                link.wr_data <= 9'h000;
            end
        end else begin
            if (rise)
                dq_oe <= 1'b0;
            unique case (phase_q)
                PH_CMD: if (rise) begin
                    cmd_q <= cmd_full;
                    bit_q <= bit_q + 4'h1;
                    if (bit_q == tt_pkg::CMD_LAST_BIT) begin
                        bit_q          <= 4'h0;
                        link.cmd_valid <= 1'b1;
                        phase_q <= is_write ? PH_WRITE
                                 : is_read  ? PH_READ : PH_DONE;
                    end
                end
                PH_WRITE: if (rise) begin
                    wr_sr_q <= wr_full;
                    bit_q   <= bit_q + 4'h1;
                    if (bit_q == wr_last) begin
                        link.wr_valid <= 1'b1;
                        link.wr_data  <= is_cfg ? {1'b0, wr_full[8:1]}
                                                : wr_full;
                        phase_q       <= PH_DONE;
                    end
                end
                PH_READ: if (fall) begin
                    // Zero fill keeps the pin at 0 after the last bit.
                    dq_oe    <= 1'b1;
                    dq_out   <= rd_src[0];
                    rd_sr_q  <= {1'b0, rd_src[8:1]};
                    loaded_q <= 1'b1;
                end
                PH_DONE: ;
            endcase
        end
    end

endmodule

/* File: bench/tt_host_model.sv */
// Host controller model driving the three-wire serial port.
`timescale 1ns/100ps

module tt_host_model (
    // Clock
    input  wire logic mclk,
    // Data pin as driven by the device
    input  wire logic dq_out,
    input  wire logic dq_oe,
    // Pins
    output logic      sel,
    output logic      sck,
    output logic      dq
);
    logic h_dq = 1'b0;
    initial sel = 1'b0;
    initial sck = 1'b1;
    assign dq = dq_oe ? dq_out : h_dq;
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // ==========================================================
    // Transfers
    // ==========================================================
    // A released line toggles so that a stale bit never reads true.
    task automatic xfer(input logic [7:0] c, input int n, input logic wr,
                        input logic [15:0] w, output logic [15:0] r);
        logic [23:0] s;
        s = {w, c};
        r = 16'h0;
        sel = 1'b1;
        tick(4);
        for (int i = 0; i < 8 + n; i++) begin
            sck = 1'b0;
            h_dq = (i < 8 || wr) ? s[i] : ~h_dq;
            tick(5);
            if (i >= 8) r[i-8] = dq;
            sck = 1'b1;
            tick(3);
        end
        sel = 1'b0;
        tick(8);
    endtask
    task automatic pulse(input int n);
        sck = 1'b0;
        tick(n);
        sck = 1'b1;
        tick(3);
    endtask
endmodule

/* File: bench/tt_thermostat_asserts.sv */
// Concurrent checks on the thermostat core's pins.
`timescale 1ns/100ps

module tt_thermostat_asserts (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // Serial pins
    input wire logic SERIAL_SELECT,
    input wire logic SERIAL_CLOCK_OR_CONVERT_PIN,
    input wire logic DQ_OUT,
    input wire logic DQ_OE,
    // Thermostat outputs
    input wire logic TRIP_HIGH,
    input wire logic TRIP_LOW,
    input wire logic TRIP_COMBINED
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    property p_ch; TRIP_HIGH |-> TRIP_COMBINED; endproperty
    a_ch: assert property (p_ch) else $error("combined low");
    property p_cl; TRIP_LOW && !TRIP_HIGH |-> !TRIP_COMBINED; endproperty
    a_cl: assert property (p_cl) else $error("combined high");
    property p_cr; $rose(TRIP_COMBINED) |-> TRIP_HIGH; endproperty
    a_cr: assert property (p_cr) else $error("combined set");
    property p_cf; $fell(TRIP_COMBINED) |-> TRIP_LOW; endproperty
    a_cf: assert property (p_cf) else $error("combined clear");
    property p_so; !SERIAL_SELECT [*6] |-> !DQ_OE; endproperty
    a_so: assert property (p_so) else $error("drive unselected");
    property p_ho; SERIAL_CLOCK_OR_CONVERT_PIN [*6] |-> !DQ_OE; endproperty
    a_ho: assert property (p_ho) else $error("drive clock high");
    property p_ol; $rose(DQ_OE) |-> !$past(SERIAL_CLOCK_OR_CONVERT_PIN, 3);
    endproperty
    a_ol: assert property (p_ol) else $error("drive not on fall");
    property p_dh; DQ_OE && $past(DQ_OE) |-> $stable(DQ_OUT); endproperty
    a_dh: assert property (p_dh) else $error("data moved");
endmodule

/* File: bench/test_tt_thermostat.sv */
// Self-checking bench for the thermometer/thermostat core.
`timescale 1ns/100ps

module test_tt_thermostat;
    logic        MCLK = 1'b0;
    logic        RST_N = 1'b0;
    logic [8:0]  t_in = 9'h000;
    logic [8:0]  c_in = 9'h05a;
    logic [8:0]  s_in = 9'h0a5;
    logic        sel, sck, dq, dq_out, dq_oe, t_hi, t_lo, t_cm;
    logic [15:0] rd;
    int          err_total = 0;
    int          total_checks = 0;
    initial forever #10 MCLK = ~MCLK;
    tt_host_model host_u (.mclk(MCLK), .dq_out(dq_out), .dq_oe(dq_oe),
        .sel(sel), .sck(sck), .dq(dq));
    tt_thermostat #(.CONV_CYCLES(20), .NV_WRITE_CYCLES(400)) dut_u (
        .MCLK(MCLK), .RST_N(RST_N), .SERIAL_SELECT(sel),
        .SERIAL_CLOCK_OR_CONVERT_PIN(sck), .DQ_IN(dq), .DQ_OUT(dq_out),
        .DQ_OE(dq_oe), .SENSOR_TEMP(t_in), .SENSOR_COUNT_REMAIN(c_in),
        .SENSOR_SLOPE(s_in), .TRIP_HIGH(t_hi), .TRIP_LOW(t_lo),
        .TRIP_COMBINED(t_cm));
    task automatic chk(input string nm, input logic [15:0] e, s);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rdc(input logic [7:0] c, input int n, input logic [15:0] e);
        host_u.xfer(c, n, 1'b0, 16'h0000, rd);
        chk($sformatf("read %h", c), e, rd);
    endtask
    // Every write waits out the busy time, since writes meanwhile drop.
    task automatic wrc(input logic [7:0] c, input int n, input logic [15:0] w);
        host_u.xfer(c, n, 1'b1, w, rd);
        host_u.tick(410);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge MCLK);
        #1 RST_N = 1'b1;
        rdc(8'hac, 8, 16'h0088);
        rdc(8'ha1, 9, 16'h001e);
        rdc(8'ha2, 9, 16'h0014);
        host_u.xfer(8'h01, 9, 1'b1, 16'h0032, rd);
        rdc(8'hac, 8, 16'h0098);
        host_u.tick(300);
        rdc(8'ha1, 16, 16'h0032);
        wrc(8'h02, 16, 16'hfdce);
        rdc(8'ha2, 9, 16'h01ce);
        $display("test limits done");
        wrc(8'h0c, 8, 16'h0003);
        t_in = 9'h032;
        host_u.xfer(8'hee, 0, 1'b1, 16'h0000, rd);
        host_u.tick(40);
        rdc(8'haa, 16, 16'h0032);
        chk("trips", 16'h0005, {t_hi, t_lo, t_cm});
        rdc(8'hac, 8, 16'h00cb);
        t_in = 9'h1ce;
        host_u.tick(60);
        chk("trips", 16'h0005, {t_hi, t_lo, t_cm});
        c_in = 9'h123;
        host_u.xfer(8'hee, 0, 1'b1, 16'h0000, rd);
        host_u.tick(40);
        rdc(8'haa, 9, 16'h01ce);
        c_in = 9'h0f0;
        chk("trips", 16'h0002, {t_hi, t_lo, t_cm});
        rdc(8'hac, 8, 16'h00eb);
        wrc(8'h0c, 8, 16'h0003);
        rdc(8'hac, 8, 16'h008b);
        rdc(8'ha0, 9, 16'h0123);
        rdc(8'ha9, 9, 16'h00a5);
        s_in = 9'h111;
        rdc(8'ha0, 9, 16'h00a5);
        $display("test single done");
        wrc(8'h0c, 8, 16'h0001);
        t_in = 9'h000;
        host_u.pulse(10);
        host_u.tick(40);
        rdc(8'haa, 9, 16'h0000);
        wrc(8'h0c, 8, 16'h0003);
        t_in = 9'h032;
        host_u.pulse(10);
        host_u.tick(40);
        rdc(8'haa, 9, 16'h0000);
        $display("test pin done");
        wrc(8'h0c, 8, 16'h0002);
        host_u.xfer(8'hee, 0, 1'b1, 16'h0000, rd);
        host_u.tick(50);
        t_in = 9'h1ce;
        host_u.tick(50);
        rdc(8'haa, 9, 16'h01ce);
        host_u.xfer(8'h22, 0, 1'b1, 16'h0000, rd);
        host_u.tick(30);
        t_in = 9'h000;
        host_u.tick(60);
        rdc(8'haa, 9, 16'h01ce);
        $display("test continuous done");
        stop_test();
    end
endmodule

bind tt_thermostat tt_thermostat_asserts chk_u (.MCLK(MCLK), .RST_N(RST_N),
    .SERIAL_SELECT(SERIAL_SELECT), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
    .SERIAL_CLOCK_OR_CONVERT_PIN(SERIAL_CLOCK_OR_CONVERT_PIN),
    .TRIP_HIGH(TRIP_HIGH), .TRIP_LOW(TRIP_LOW), .TRIP_COMBINED(TRIP_COMBINED));
